/* File: shared/tdt_pkg.sv */
// constants shared by the down-count timer and its pwm stage
package tdt_pkg;
  localparam int CNT_W = 10;
  localparam int DAT_W = 8;
  localparam int ADR_W = 4;
  localparam int PS_W = 8;

  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [ADR_W-1:0] ADR_CNT_LOW = 4'h0;
  localparam logic [ADR_W-1:0] ADR_CTRL_ONE = 4'h1;
  localparam logic [ADR_W-1:0] ADR_CTRL_TWO = 4'h2;
  localparam logic [ADR_W-1:0] ADR_DUTY_LOW = 4'h3;
  localparam logic [ADR_W-1:0] ADR_HIGH_BITS = 4'h8;
  localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 4'h9;
  localparam logic [ADR_W-1:0] ADR_IRQ_CLR = 4'ha;
  localparam logic [ADR_W-1:0] ADR_IRQ_EN = 4'hb;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int C1_EN = 0;
  localparam int C1_RELOAD = 1;
  localparam int C1_ONESHOT = 2;
  localparam int C1_POL = 6;
  localparam int C1_PIN_EN = 7;
  localparam int C2_RATE = 0;
  localparam int C2_PSDIS = 3;
  localparam int C2_EDGE = 4;
  localparam int C2_SRC = 5;
  localparam int HB_DUTY = 0;
  localparam int HB_CNT = 2;
  localparam int HB_RELOAD = 4;
  localparam int HB_HOSC = 6;
  localparam int IRQ_UNDER = 0;

  // --------------------------------------------------------------
  // reset values and masks
  // --------------------------------------------------------------
  localparam logic [DAT_W-1:0] CTRL_ONE_RST = 8'h00;
  localparam logic [DAT_W-1:0] CTRL_TWO_RST = 8'h3f;
  localparam logic [DAT_W-1:0] CTRL_ONE_MASK = 8'hc7;
  localparam logic [DAT_W-1:0] CTRL_TWO_MASK = 8'h3f;
  localparam logic [DAT_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_ALL_ONES = 10'h3ff;
  localparam logic [CNT_W-1:0] COUNT_ZERO = 10'h000;
  localparam logic [PS_W-1:0] PS_ZERO = 8'h00;
endpackage : tdt_pkg

/* File: shared/tdt_if.sv */
// carrier between the timer core, its prescaler and its pwm stage
`timescale 1ns/1ns
`default_nettype none
interface tdt_if;
  import tdt_pkg::*;
  logic tick_raw;
  logic bypass;
  logic [2:0] rate;
  logic tick_out;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] duty;
  logic polarity;
  logic pwm_level;
  modport ps (input tick_raw, bypass, rate, output tick_out);
  modport pw (input count, duty, polarity, output pwm_level);
  modport core (output tick_raw, bypass, rate, count, duty, polarity,
                input tick_out, pwm_level);
endinterface : tdt_if
`default_nettype wire

/* File: hw/tdt_prescaler.sv */
// power-of-two prescaler in front of the timer count
`timescale 1ns/1ns
`default_nettype none
module tdt_prescaler import tdt_pkg::*; (
  input wire logic mclk_in,
  input wire logic nrst_in,
  tdt_if.ps bus
);
  typedef struct packed {
    logic [PS_W-1:0] cnt;
    logic tick;
  } tdt_ps_type;
  tdt_ps_type st_q, st_d;

  function automatic logic [PS_W-1:0] rate_mask(input logic [2:0] r);
    rate_mask = PS_W'((9'h002 << r) - 9'h001);
  endfunction : rate_mask

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (bus.bypass) begin
      st_d.tick = bus.tick_raw;
      st_d.cnt = PS_ZERO;
    end else if (bus.tick_raw) begin
      st_d.tick = (st_q.cnt & rate_mask(bus.rate)) == rate_mask(bus.rate);
      st_d.cnt = st_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) st_q <= '0;
    else st_q <= st_d;
  end

  assign bus.tick_out = st_q.tick;

  chk_bypass_pass: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    $past(bus.bypass) |-> bus.tick_out == $past(bus.tick_raw))
    else $error("bypassed prescaler did not pass the tick");
  // ticks launched while bypassed follow every raw tick and may sit side by side; bypass
  // clears the divider count, so only ticks launched with the divider in the path are judged
  chk_div_two: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !$past(bus.bypass) && $past(bus.rate) == 3'h0 && bus.tick_out
    |-> !$past(bus.tick_out))
    else $error("divide by two gave two ticks in a row");
endmodule : tdt_prescaler
`default_nettype wire

/* File: hw/tdt_pwm.sv */
// pwm level from the running count and the duty value
`timescale 1ns/1ns
`default_nettype none
module tdt_pwm import tdt_pkg::*; (
  input wire logic mclk_in,
  input wire logic nrst_in,
  tdt_if.pw bus
);
  typedef struct packed {
    logic level;
  } tdt_pw_type;
  tdt_pw_type st_q, st_d;

  always_comb begin
    st_d = st_q;
    // frame from the count's reload or all-ones wrap, width from duty
    st_d.level = (bus.count < bus.duty) ^ bus.polarity;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) st_q <= '0;
    else st_q <= st_d;
  end

  assign bus.pwm_level = st_q.level;

  chk_pwm_polarity: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    bus.pwm_level ==
      (($past(bus.count) < $past(bus.duty)) ^ $past(bus.polarity)))
    else $error("pwm level disagrees with duty and polarity");
endmodule : tdt_pwm
`default_nettype wire

/* File: hw/tdt_top.sv */
// ten-bit down-count timer with prescaler, pwm and underflow interrupt
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module tdt_top import tdt_pkg::*; (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [ADR_W-1:0] addr_in,
  input wire logic [DAT_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DAT_W-1:0] rdata_out,
  input wire logic ext_clock_pin_in,
  input wire logic hosc_tick_in,
  input wire logic gpio_b3_out_in,
  input wire logic gpio_b3_oe_in,
  input wire logic gpio_b4_out_in,
  input wire logic gpio_b4_oe_in,
  output logic port_b_pin_three_out,
  output logic port_b_pin_three_oe_out,
  output logic port_b_pin_four_out,
  output logic port_b_pin_four_oe_out,
  output logic irq_out
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [DAT_W-1:0] reload_low;
    logic [1:0] reload_high;
    logic [DAT_W-1:0] duty_low;
    logic [1:0] duty_high;
    logic hosc_sel;
    logic [DAT_W-1:0] ctrl_one;
    logic [DAT_W-1:0] ctrl_two;
    logic stopped;
    logic irq_stat;
    logic irq_en;
    logic [DAT_W-1:0] rdata;
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;
  } tdt_st_type;

  tdt_st_type st_q, st_d;
  tdt_if link ();

  logic count_enable;
  logic reload_select;
  logic one_shot_select;
  logic pwm_polarity;
  logic pwm_pin_enable;
  logic [2:0] prescale_rate;
  logic prescale_disable_n;
  logic ext_edge_select;
  logic clock_source_select;
  logic [CNT_W-1:0] reload_value;
  logic ext_edge;
  logic count_tick;
  logic underflow;
  logic wr_count;

  function automatic logic sel(input logic [ADR_W-1:0] a,
                               input logic [ADR_W-1:0] b);
    sel = (a == b);
  endfunction : sel

  // --------------------------------------------------------------
  // control fields
  // --------------------------------------------------------------
  assign count_enable = st_q.ctrl_one[C1_EN];
  assign reload_select = st_q.ctrl_one[C1_RELOAD];
  assign one_shot_select = st_q.ctrl_one[C1_ONESHOT];
  assign pwm_polarity = st_q.ctrl_one[C1_POL];
  assign pwm_pin_enable = st_q.ctrl_one[C1_PIN_EN];
  assign prescale_rate = st_q.ctrl_two[C2_RATE +: 3];
  assign prescale_disable_n = st_q.ctrl_two[C2_PSDIS];
  assign ext_edge_select = st_q.ctrl_two[C2_EDGE];
  assign clock_source_select = st_q.ctrl_two[C2_SRC];
  assign reload_value = {st_q.reload_high, st_q.reload_low};
  assign wr_count = wr_in && sel(addr_in, ADR_CNT_LOW);

  // --------------------------------------------------------------
  // timer clock path
  // --------------------------------------------------------------
  // edge select picks falling or rising
  assign ext_edge = ext_edge_select ? (st_q.ext_prev && !st_q.ext_sync2)
                                    : (!st_q.ext_prev && st_q.ext_sync2);

  always_comb begin
    if (clock_source_select) link.tick_raw = ext_edge;
    // the high oscillator arrives as a tick already on mclk
    else if (st_q.hosc_sel) link.tick_raw = hosc_tick_in;
    else link.tick_raw = 1'b1;
  end

  assign link.bypass = prescale_disable_n;
  assign link.rate = prescale_rate;
  // high oscillator relies on firmware setting bypass
  // a rate change while enabled may give a stray tick

  tdt_prescaler u_presc (
    .mclk_in (mclk_in),
    .nrst_in (nrst_in),
    .bus (link.ps)
  );

  assign count_tick = link.tick_out && count_enable && !st_q.stopped;
  assign underflow = count_tick && st_q.count == COUNT_ZERO;

  // --------------------------------------------------------------
  // pwm
  // --------------------------------------------------------------
  assign link.count = st_q.count;
  // duty from high bits and duty byte
  assign link.duty = {st_q.duty_high, st_q.duty_low};
  assign link.polarity = pwm_polarity;

  tdt_pwm u_pwm (
    .mclk_in (mclk_in),
    .nrst_in (nrst_in),
    .bus (link.pw)
  );

  // pwm takes over both port b pins
  always_comb begin
    if (pwm_pin_enable) begin
      port_b_pin_three_out = link.pwm_level;
      port_b_pin_three_oe_out = 1'b1;
      port_b_pin_four_out = link.pwm_level;
      port_b_pin_four_oe_out = 1'b1;
    end else begin
      port_b_pin_three_out = gpio_b3_out_in;
      port_b_pin_three_oe_out = gpio_b3_oe_in;
      port_b_pin_four_out = gpio_b4_out_in;
      port_b_pin_four_oe_out = gpio_b4_oe_in;
    end
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rdata = ZERO_BYTE;
    st_d.ext_sync1 = ext_clock_pin_in;
    st_d.ext_sync2 = st_q.ext_sync1;
    st_d.ext_prev = st_q.ext_sync2;

    // down-count and underflow handling
    if (count_tick) begin
      if (st_q.count != COUNT_ZERO) begin
        st_d.count = st_q.count - 10'h001;
      end else if (one_shot_select) begin
        st_d.stopped = 1'b1;
      end else if (reload_select) begin
        st_d.count = reload_value;
      end else begin
        st_d.count = COUNT_ALL_ONES;
      end
    end

    // register writes
    if (wr_in) begin
      unique case (addr_in)
        ADR_CNT_LOW: begin
          st_d.reload_low = wdata_in;
          st_d.count = {st_q.reload_high, wdata_in};
          st_d.stopped = 1'b0;
        end
        ADR_CTRL_ONE: st_d.ctrl_one = wdata_in & CTRL_ONE_MASK;
        ADR_CTRL_TWO: st_d.ctrl_two = wdata_in & CTRL_TWO_MASK;
        ADR_DUTY_LOW: st_d.duty_low = wdata_in;
        ADR_HIGH_BITS: begin
          st_d.duty_high = wdata_in[HB_DUTY +: 2];
          st_d.reload_high = wdata_in[HB_RELOAD +: 2];
          st_d.hosc_sel = wdata_in[HB_HOSC];
        end
        ADR_IRQ_CLR: begin
          if (wdata_in[IRQ_UNDER]) st_d.irq_stat = 1'b0;
        end
        ADR_IRQ_EN: st_d.irq_en = wdata_in[IRQ_UNDER];
        default: ;
      endcase
    end

    // underflow sets the flag, set beats clear
    if (underflow) st_d.irq_stat = 1'b1;

    // register reads, data in the following cycle
    if (rd_in) begin
      unique case (addr_in)
        ADR_CNT_LOW: st_d.rdata = st_q.count[DAT_W-1:0];
        ADR_CTRL_ONE: st_d.rdata = st_q.ctrl_one;
        ADR_CTRL_TWO: st_d.rdata = st_q.ctrl_two;
        ADR_DUTY_LOW: st_d.rdata = st_q.duty_low;
        ADR_HIGH_BITS: begin
          st_d.rdata[HB_DUTY +: 2] = st_q.duty_high;
          st_d.rdata[HB_CNT +: 2] = st_q.count[CNT_W-1 -: 2];
          st_d.rdata[HB_RELOAD +: 2] = st_q.reload_high;
          st_d.rdata[HB_HOSC] = st_q.hosc_sel;
        end
        ADR_IRQ_STAT: st_d.rdata[IRQ_UNDER] = st_q.irq_stat;
        ADR_IRQ_EN: st_d.rdata[IRQ_UNDER] = st_q.irq_en;
        default: st_d.rdata = ZERO_BYTE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= '0;
      st_q.ctrl_one <= CTRL_ONE_RST;
      st_q.ctrl_two <= CTRL_TWO_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_out = st_q.rdata;
  assign irq_out = st_q.irq_stat && st_q.irq_en;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  chk_count_read: assert property (
    rd_in && sel(addr_in, ADR_CNT_LOW)
    |=> rdata_out == $past(st_q.count[DAT_W-1:0]))
    else $error("count read returned a stale value");
  chk_count_load: assert property (
    wr_count |=> st_q.count == {st_q.reload_high, $past(wdata_in)}
                 && !st_q.stopped)
    else $error("count write did not load the reload value");
  chk_count_hold: assert property (
    !count_enable && !wr_count |=> $stable(st_q.count))
    else $error("count moved while disabled");
  chk_reload_wrap: assert property (
    underflow && !one_shot_select && reload_select && !wr_count
    |=> st_q.count == $past(reload_value))
    else $error("non-stop reload did not take the reload value");
  chk_ones_wrap: assert property (
    underflow && !one_shot_select && !reload_select && !wr_count
    |=> st_q.count == COUNT_ALL_ONES)
    else $error("non-stop underflow did not restart from all ones");
  chk_oneshot_stop: assert property (
    underflow && one_shot_select && !wr_count
    |=> st_q.stopped && st_q.count == COUNT_ZERO ##1
        st_q.count == COUNT_ZERO || $past(wr_count))
    else $error("one-shot did not park at zero");
  chk_pin_mux: assert property (
    pwm_pin_enable |-> port_b_pin_three_oe_out && port_b_pin_four_oe_out
      && port_b_pin_three_out == link.pwm_level
      && port_b_pin_four_out == link.pwm_level)
    else $error("pwm not on port b pins");
  chk_ext_source: assert property (
    clock_source_select |-> link.tick_raw == (ext_edge_select
      ? ($past(st_q.ext_sync2) && !st_q.ext_sync2)
      : (!$past(st_q.ext_sync2) && st_q.ext_sync2)))
    else $error("external edge not routed to the prescaler");
  chk_irq_set: assert property (
    underflow |=> st_q.irq_stat ##0 (irq_out == st_q.irq_en))
    else $error("underflow did not set the event flag");

  cov_reload: cover property (underflow && reload_select ##1 count_tick);
  cov_oneshot: cover property (underflow && one_shot_select);
  cov_irq: cover property ($rose(irq_out));
  cov_ext: cover property (clock_source_select && count_tick);
endmodule : tdt_top
`default_nettype wire

/* File: bench/tdt_far_side.sv */
// far side model: external clock pin and high oscillator ticks
`timescale 1ns/1ns
`default_nettype none
module tdt_far_side (
  input wire logic mclk_in,
  output logic ext_clock_pin_out,
  output logic hosc_tick_out
);
  initial begin
    ext_clock_pin_out = 1'b0;
    hosc_tick_out = 1'b0;
  end

  // flips are spaced over three clocks and off the clock grid, so the
  // synchroniser sees every level; the pin stands still between calls
  task toggle(input int n);
    repeat (n) begin
      #330;
      ext_clock_pin_out = ~ext_clock_pin_out;
    end
    #330;
  endtask : toggle

  // one full pulse gives one rising and one falling edge
  task pulse(input int n);
    repeat (n) toggle(2);
  endtask : pulse

  // ticks are one clock wide and launched just after an edge
  task hosc_burst(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      hosc_tick_out <= 1'b1;
      @(posedge mclk_in);
      hosc_tick_out <= 1'b0;
    end
  endtask : hosc_burst
endmodule : tdt_far_side
`default_nettype wire

/* File: bench/tdt_top_test.sv */
// self-checking bench for the down-count timer with pwm
`timescale 1ns/1ns
`default_nettype none
module tdt_top_test import tdt_pkg::*;;
  localparam logic [7:0] MODE_C1 [4] = '{8'h03, 8'h01, 8'h05, 8'h07};
  localparam int MODE_N [4] = '{4, 3, 5, 5};
  localparam logic [9:0] MODE_V [4] = '{10'h001, 10'h3ff, 10'h000, 10'h000};
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [ADR_W-1:0] addr_in;
  logic [DAT_W-1:0] wdata_in, rdata_out;
  logic wr_in, rd_in, rd_seen = 1'b0, irq_out, ext_pin, hosc_tick;
  logic b3o, b3e, b4o, b4e, p3, p3e, p4, p4e, hosc_sel = 1'b0;
  logic [1:0] reload_hi = 2'b00;
  logic [DAT_W-1:0] expq [$];
  int fails = 0;
  int checks = 0;

  tdt_top u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .ext_clock_pin_in(ext_pin), .hosc_tick_in(hosc_tick),
    .gpio_b3_out_in(b3o), .gpio_b3_oe_in(b3e), .gpio_b4_out_in(b4o),
    .gpio_b4_oe_in(b4e), .port_b_pin_three_out(p3),
    .port_b_pin_three_oe_out(p3e), .port_b_pin_four_out(p4),
    .port_b_pin_four_oe_out(p4e), .irq_out(irq_out));
  tdt_far_side u_far (.mclk_in(mclk_in), .ext_clock_pin_out(ext_pin),
    .hosc_tick_out(hosc_tick));

  always #50 mclk_in = ~mclk_in;

  // --------------------------------------------------------------
  // bus tasks and comparison
  // --------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [7:0] exp);
    expq.push_back(exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
  endtask : rd

  task idle(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : idle

  // the high byte also carries the reload bits, so set it first
  task load(input logic [9:0] v);
    reload_hi = v[9:8];
    wr(ADR_HIGH_BITS, {1'b0, hosc_sel, v[9:8], 4'h0});
    wr(ADR_CNT_LOW, v[7:0]);
  endtask : load

  task rdcnt(input logic [9:0] v);
    rd(ADR_CNT_LOW, v[7:0]);
    rd(ADR_HIGH_BITS, {1'b0, hosc_sel, reload_hi, v[9:8], 2'b00});
  endtask : rdcnt

  task results;
    $display("comparisons %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // read data stands only in the cycle after the strobe
  always @(posedge mclk_in) begin
    if (rd_seen)
      chk(rdata_out, expq.pop_front());
    rd_seen <= rd_in;
  end

  // about 6,000 clocks of traffic expected; allow five times that
  initial begin
    #3000000;
    fails++;
    results();
  end

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    logic [9:0] v;
    logic [7:0] g;
    logic lvl;
    int n;
    int cnt;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    g = 8'($urandom(11504));
    {b4e, b4o, b3e, b3o} = g[3:0];
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    rd(ADR_CTRL_ONE, CTRL_ONE_RST);
    rd(ADR_CTRL_TWO, CTRL_TWO_RST);
    rd(4'h5, 8'h00);
    rd(ADR_IRQ_CLR, 8'h00);
    wr(ADR_CTRL_ONE, 8'hff);
    rd(ADR_CTRL_ONE, CTRL_ONE_MASK);
    wr(ADR_CTRL_ONE, 8'h00);
    idle(2);
    chk({4'h0, p3, p3e, p4, p4e}, {4'h0, b3o, b3e, b4o, b4e});
    // instruction clock ticks every cycle, but the count is held
    wr(ADR_CTRL_TWO, 8'h18);
    v = 10'($urandom);
    load(v);
    idle(20);
    rdcnt(v);
    // high oscillator ticks with the prescaler kept out
    hosc_sel = 1'b1;
    load(10'h100);
    wr(ADR_CTRL_ONE, 8'h01);
    u_far.hosc_burst(5);
    idle(4);
    wr(ADR_CTRL_ONE, 8'h00);
    rdcnt(10'h0fb);
    hosc_sel = 1'b0;
    // instruction clock: bypassed, one step per enabled edge
    wr(ADR_CTRL_TWO, 8'h08);
    load(10'h100);
    wr(ADR_CTRL_ONE, 8'h01);
    idle(3);
    wr(ADR_CTRL_ONE, 8'h00);
    rdcnt(10'h0fb);
    // same clock through the divider at rate code 0: every second edge
    wr(ADR_CTRL_TWO, 8'h00);
    wr(ADR_CTRL_ONE, 8'h01);
    idle(6);
    wr(ADR_CTRL_ONE, 8'h00);
    rdcnt(10'h0f7);
    // external edge select, random number of pin flips
    for (int e = 1; e >= 0; e--) begin
      wr(ADR_CTRL_TWO, (e == 1) ? 8'h3f : 8'h2f);
      load(10'h200);
      wr(ADR_CTRL_ONE, 8'h01);
      n = 1 + int'($urandom % 6);
      lvl = ext_pin;
      cnt = 0;
      for (int i = 0; i < n; i++) begin
        if (lvl == e[0])
          cnt++;
        lvl = ~lvl;
      end
      u_far.toggle(n);
      idle(8);
      wr(ADR_CTRL_ONE, 8'h00);
      rdcnt(10'h200 - 10'(cnt));
    end
    // underflow handling in every mode, event flag each time
    wr(ADR_CTRL_TWO, 8'h3f);
    wr(ADR_IRQ_EN, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(ADR_IRQ_CLR, 8'h01);
      load(10'h002);
      wr(ADR_CTRL_ONE, MODE_C1[m]);
      u_far.pulse(MODE_N[m]);
      idle(8);
      wr(ADR_CTRL_ONE, 8'h00);
      rdcnt(MODE_V[m]);
      rd(ADR_IRQ_STAT, 8'h01);
    end
    idle(2);
    chk({7'h0, irq_out}, 8'h01);
    wr(ADR_IRQ_EN, 8'h00);
    idle(2);
    chk({7'h0, irq_out}, 8'h00);
    wr(ADR_IRQ_EN, 8'h01);
    wr(ADR_IRQ_CLR, 8'h01);
    idle(2);
    chk({7'h0, irq_out}, 8'h00);
    rd(ADR_IRQ_STAT, 8'h00);
    // every prescale code, rate changed only while bypassed
    load(10'h3ff);
    for (int r = 0; r < 8; r++) begin
      wr(ADR_CTRL_TWO, {5'b00111, 3'(r)});
      wr(ADR_CTRL_TWO, {5'b00110, 3'(r)});
      wr(ADR_CTRL_ONE, 8'h01);
      u_far.pulse(2 << r);
      idle(8);
      wr(ADR_CTRL_ONE, 8'h00);
      wr(ADR_CTRL_TWO, {5'b00111, 3'(r)});
      rdcnt(10'h3fe - 10'(r));
    end
    // pwm level on both pins against a fixed duty of 0x010
    wr(ADR_DUTY_LOW, 8'h10);
    for (int c = 0; c < 2; c++) begin
      load((c == 0) ? 10'h005 : 10'h3ff);
      for (int p = 0; p < 2; p++) begin
        wr(ADR_CTRL_ONE, {1'b1, p[0], 6'h00});
        idle(3);
        lvl = (c == 0) ^ p[0];
        chk({4'h0, p3, p3e, p4, p4e}, {4'h0, lvl, 1'b1, lvl, 1'b1});
      end
    end
    idle(4);
    results();
  end
endmodule : tdt_top_test
`default_nettype wire
